/* hw/dcs_pkg.sv */
// drive command source select: shared constants, register map and types
// assumes a single 100 MHz core clock and an AXI4-Lite register bus
package dcs_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int DEBOUNCE_NS  = 1000;   // contact must be stable this long
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int DB_W         = 7;
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);
  // power-up window: longer than one debounce so pins have settled
  localparam int PWRUP_CYC    = DEBOUNCE_CYC + 4;
  localparam int PU_W         = 7;
  localparam logic [PU_W-1:0] PU_LAST = PU_W'(PWRUP_CYC - 1);
  localparam int DI_N         = 5;

  // ------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_KEYPAD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SPEED  = 8'h0C;
  localparam logic [7:0] REG_SCALE  = 8'h10;

  localparam int CTRL_SRC_LSB   = 0;    // command_source_select, 3 bits
  localparam int CTRL_MACRO_LSB = 8;    // input_macro_select, 5 bits
  localparam int CTRL_AUTO_BIT  = 16;   // power_on_autostart
  localparam int CTRL_KS_LSB    = 17;   // keypad_start_behaviour, 2 bits
  localparam int KS_EN_START    = 0;    // enable alone starts
  localparam int KS_REF_HOLD    = 1;    // keep keypad speed at start
  localparam int KPD_START_BIT  = 0;
  localparam int KPD_STOP_BIT   = 1;
  localparam int KPD_REF_LSB    = 16;
  localparam int STS_RUN_BIT    = 0;
  localparam int STS_REV_BIT    = 1;
  localparam int STS_LOCK_BIT   = 2;
  localparam int STS_DI_LSB     = 8;
  localparam int STS_SRC_LSB    = 16;
  localparam int SCALE_FRAC     = 8;    // unsigned 8.8 slave scaling

  localparam logic [2:0]  SRC_RST   = 3'h0;
  localparam logic [4:0]  MACRO_RST = 5'h01;
  localparam logic [15:0] SCALE_RST = 16'h0100;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // macro groups by highest macro number in each group
  localparam logic [4:0] MACRO_LATCH_MAX  = 5'h07;
  localparam logic [4:0] MACRO_RUNDIR_MAX = 5'h0B;
  localparam logic [4:0] MACRO_PULSE_MAX  = 5'h0F;
  localparam logic [4:0] MACRO_PAIR_MAX   = 5'h11;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_TERMINAL = 3'h0, SRC_KPD_UNI = 3'h1, SRC_KPD_BI = 3'h2,
    SRC_PID      = 3'h3, SRC_FIELDBUS = 3'h4, SRC_SLAVE = 3'h5,
    SRC_CAN      = 3'h6
  } dcs_src_t;

  typedef enum logic [2:0] {
    CLS_LATCH = 3'h0, CLS_RUNDIR = 3'h1, CLS_PULSE = 3'h2,
    CLS_PAIR  = 3'h3, CLS_DIRPULSE = 3'h4
  } dcs_class_t;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'h0, RUN_ACTIVE = 2'h1, RUN_LOCK = 2'h2
  } dcs_run_t;

endpackage

/* hw/dcs_debounce.sv */
// one terminal input: two-stage synchroniser followed by a debouncer
// assumes the pin is asynchronous to aclk; output is a clean level
`timescale 1ns/1ps
module dcs_debounce
  import dcs_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic            s1;
    logic            s2;
    logic            lvl;
    logic [DB_W-1:0] cnt;
  } dcs_db_t;

  dcs_db_t r;
  dcs_db_t n;

  // ------------------------------------------------------------------
  // filter
  // ------------------------------------------------------------------
  // a change is taken only after it has held for a whole debounce span
  always_comb begin
    n    = r;
    n.s1 = pin;
    n.s2 = r.s1;
    if (r.s2 == r.lvl) begin
      n.cnt = '0;                             // bounce restarts the span
    end else if (r.cnt == DB_LAST) begin
      n.lvl = r.s2;
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.lvl;

  a_db_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(level) |-> $past(r.s2) == level)
    else $error("debounced level changed without stable input");

endmodule // dcs_debounce

/* hw/dcs_top.sv */
// drive command source select: run/stop, direction and speed reference
// assumes DI pins are asynchronous; source inputs are on-chip, on aclk
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [4:0]  di_pin,
  input  wire logic [15:0] ai1_ref,
  input  wire logic [15:0] pid_ref,
  input  wire logic        option_fitted,
  input  wire logic        fb_run,
  input  wire logic        fb_reverse,
  input  wire logic [15:0] fb_ref,
  input  wire logic        mb_run,
  input  wire logic        mb_reverse,
  input  wire logic [15:0] mb_ref,
  input  wire logic        ms_run,
  input  wire logic        ms_reverse,
  input  wire logic [15:0] ms_ref,
  input  wire logic        can_run,
  input  wire logic        can_reverse,
  input  wire logic [15:0] can_ref,
  output logic             run_cmd,
  output logic             reverse_cmd,
  output logic [15:0]      speed_ref
);

  typedef struct packed {
    logic [2:0]      src;
    logic [4:0]      macro;
    logic            autostart;
    logic [1:0]      kstart;
    logic [15:0]     scale;
    logic [15:0]     kpd_ref;
    logic            kpd_go;
    logic            kpd_halt;
    dcs_run_t        fsm;
    logic            run;
    logic            direction_reverse_select;
    logic [15:0]     spd;
    logic [4:0]      di_q;
    logic [PU_W-1:0] pu_cnt;
    logic            first;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } dcs_state_t;

  dcs_state_t    r;
  dcs_state_t    n;
  logic [4:0]    db;
  logic [4:0]    rise;
  logic [4:0]    fall;
  logic          en;
  logic          pu_done;
  logic          wr_go;
  logic          rd_go;
  logic [31:0]   ctrl_word;
  logic [31:0]   status_word;
  logic [31:0]   prod;
  logic [15:0]   scaled;
  dcs_class_t    cls;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // byte-lane merge for partial AXI writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction

  // macro number to terminal function group
  function automatic dcs_class_t macro_class(input logic [4:0] m);
    if (m <= MACRO_LATCH_MAX) begin
      return CLS_LATCH;
    end else if (m <= MACRO_RUNDIR_MAX) begin
      return CLS_RUNDIR;
    end else if (m <= MACRO_PULSE_MAX) begin
      return CLS_PULSE;
    end else if (m <= MACRO_PAIR_MAX) begin
      return CLS_PAIR;
    end
    return CLS_DIRPULSE;
  endfunction

  // ------------------------------------------------------------------
  // terminal inputs
  // ------------------------------------------------------------------
  // every pin is synchronised and filtered before any decode
  for (genvar g = 0; g < DI_N; g++) begin : g_di
    dcs_debounce u_db (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (di_pin[g]),
      .level   (db[g])
    );
  end

  // edges compare against last cycle's filtered level
  assign rise    = db & ~r.di_q;
  assign fall    = ~db & r.di_q;
  assign en      = db[0];
  assign pu_done = (r.pu_cnt == PU_LAST);
  assign cls     = macro_class(r.macro);

  // slave follows master with 8.8 scaling, saturating on overflow
  assign prod    = {16'h0000, ms_ref} * {16'h0000, r.scale};
  assign scaled  = (|prod[31:16+SCALE_FRAC]) ? 16'hFFFF
                                             : prod[15+SCALE_FRAC:SCALE_FRAC];

  // ------------------------------------------------------------------
  // bus handshakes and read words
  // ------------------------------------------------------------------
  // address and data are taken together; one write outstanding
  assign wr_go   = awvalid & wvalid & ~r.bvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign rd_go   = arvalid & ~r.rvalid;
  assign arready = ~r.rvalid;

  assign ctrl_word = {13'h0000, r.kstart, r.autostart, 3'h0, r.macro,
                      5'h00, r.src};
  assign status_word = {13'h0000, r.src, 3'h0, db, 5'h00,
                        (r.fsm == RUN_LOCK), r.direction_reverse_select, r.run};

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic        start;
    logic        stop;
    logic        lvl;
    logic        nrev;
    logic [15:0] sel;
    wv       = 32'h0000_0000;
    start    = 1'b0;
    stop     = 1'b0;
    lvl      = 1'b0;
    nrev     = r.direction_reverse_select;
    sel      = 16'h0000;
    n        = r;
    n.kpd_go   = 1'b0;
    n.kpd_halt = 1'b0;
    n.di_q     = db;
    n.first    = r.first & ~pu_done;
    if (!pu_done) begin
      n.pu_cnt = r.pu_cnt + 1'b1;
    end

    // register writes; unmapped offsets answer SLVERR
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case ({awaddr[7:2], 2'b00})
        REG_CTRL: begin
          wv          = wmerge(ctrl_word, wdata, wstrb);
          n.src       = wv[CTRL_SRC_LSB +: 3];
          n.macro     = wv[CTRL_MACRO_LSB +: 5];
          n.autostart = wv[CTRL_AUTO_BIT];
          n.kstart    = wv[CTRL_KS_LSB +: 2];
        end
        REG_KEYPAD: begin
          wv         = wmerge({r.kpd_ref, 16'h0000}, wdata, wstrb);
          n.kpd_go   = wv[KPD_START_BIT];   // key press is a pulse
          n.kpd_halt = wv[KPD_STOP_BIT];
          n.kpd_ref  = wv[KPD_REF_LSB +: 16];
        end
        REG_SCALE: begin
          wv      = wmerge({16'h0000, r.scale}, wdata, wstrb);
          n.scale = wv[15:0];
        end
        REG_STATUS, REG_SPEED: ;            // read-only, write ignored
        default: n.bresp = RESP_SLVERR;
      endcase
    end else if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      unique case ({araddr[7:2], 2'b00})
        REG_CTRL:   n.rdata = ctrl_word;
        REG_KEYPAD: n.rdata = {r.kpd_ref, 16'h0000};
        REG_STATUS: n.rdata = status_word;
        REG_SPEED:  n.rdata = {16'h0000, r.spd};
        REG_SCALE:  n.rdata = {16'h0000, r.scale};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // command source: who may start, stop, steer and set speed
    unique case (r.src)
      SRC_TERMINAL: begin
        sel = ai1_ref;
        unique case (cls)
          CLS_LATCH: begin
            lvl   = 1'b1;
            start = db[0];
            nrev  = db[1];
          end
          CLS_RUNDIR: begin
            lvl   = 1'b1;
            start = db[0] ^ db[1];      // both closed reads as stop
            if (start) begin
              nrev = db[1];
            end
          end
          CLS_PULSE: begin
            start = rise[0] & db[1];
            stop  = fall[1];
            nrev  = db[2];
          end
          CLS_PAIR: begin
            start = db[0] & db[2] & (rise[0] | rise[2]) & db[1];
            stop  = fall[1];
          end
          CLS_DIRPULSE: begin
            start = (rise[0] ^ rise[2]) & db[1];
            stop  = fall[1];
            if (start) begin
              nrev = rise[2];
            end
          end
          default: stop = 1'b1;
        endcase
      end
      SRC_KPD_UNI, SRC_KPD_BI: begin
        sel = r.kpd_ref;
        if (r.kstart[KS_EN_START]) begin
          start = rise[0] | (r.first & en);
        end else begin
          start = r.kpd_go & en;
        end
        stop = r.kpd_halt | ~en;
        if (r.src == SRC_KPD_UNI) begin
          nrev = 1'b0;
        end else if (r.kpd_go && r.fsm == RUN_ACTIVE) begin
          nrev = ~r.direction_reverse_select;                // start key while running flips
        end
      end
      SRC_PID: begin
        lvl   = 1'b1;
        start = en;
        sel   = pid_ref;
        nrev  = 1'b0;
      end
      SRC_FIELDBUS: begin
        lvl   = 1'b1;
        start = en & (option_fitted ? fb_run : mb_run);
        sel   = option_fitted ? fb_ref : mb_ref;
        nrev  = option_fitted ? fb_reverse : mb_reverse;
      end
      SRC_SLAVE: begin
        lvl   = 1'b1;
        start = en & ms_run;
        sel   = scaled;
        nrev  = ms_reverse;
      end
      SRC_CAN: begin
        lvl   = 1'b1;
        start = en & can_run;
        sel   = can_ref;
        nrev  = can_reverse;
      end
      default: stop = 1'b1;             // unused code holds the drive off
    endcase
    if (lvl) begin
      stop = stop | ~start;             // level sources run only while held
    end

    // run state; a request already present at power-up is held off unless autostart is set
    unique case (r.fsm)
      RUN_IDLE: begin
        if (pu_done && start) begin
          n.fsm = (r.first && !r.autostart) ? RUN_LOCK : RUN_ACTIVE;
          if (n.fsm == RUN_ACTIVE && !r.kstart[KS_REF_HOLD] &&
              (r.src == SRC_KPD_UNI || r.src == SRC_KPD_BI)) begin
            n.kpd_ref = 16'h0000;       // keypad start from zero
          end
        end
      end
      RUN_ACTIVE: begin
        if (stop) begin
          n.fsm = RUN_IDLE;
        end
      end
      RUN_LOCK: begin
        if (!start) begin
          n.fsm = RUN_IDLE;             // request must drop and return
        end
      end
      default: n.fsm = RUN_IDLE;
    endcase
    n.run = (n.fsm == RUN_ACTIVE);
    n.direction_reverse_select = nrev;
    n.spd = sel;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.src    <= SRC_RST;
      r.macro  <= MACRO_RST;
      r.scale  <= SCALE_RST;
      r.first  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign bvalid      = r.bvalid;
  assign bresp       = r.bresp;
  assign rvalid      = r.rvalid;
  assign rresp       = r.rresp;
  assign rdata       = r.rdata;
  assign run_cmd     = r.run;
  assign reverse_cmd = r.direction_reverse_select;
  assign speed_ref   = r.spd;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_term_ref: assert property (r.src == SRC_TERMINAL |=>
    speed_ref == $past(ai1_ref)) else $error("terminal ref not AI1");
  a_kpd_fwd: assert property (r.src == SRC_KPD_UNI |=>
    !reverse_cmd && speed_ref == $past(r.kpd_ref))
    else $error("keypad uni mode wrong dir or ref");
  a_kpd_di1: assert property (r.src == SRC_KPD_BI &&
    r.kstart[KS_EN_START] && rise[0] && r.fsm == RUN_IDLE && pu_done
    && !r.first |=> run_cmd) else $error("DI1 did not start keypad");
  a_pid_ref: assert property (r.src == SRC_PID && !en |=>
    !run_cmd && speed_ref == $past(pid_ref))
    else $error("pid mode wrong");
  a_fb_select: assert property (r.src == SRC_FIELDBUS |=>
    speed_ref == $past(option_fitted ? fb_ref : mb_ref))
    else $error("fieldbus ref source wrong");
  a_slave_scale: assert property (r.src == SRC_SLAVE |=>
    speed_ref == $past(scaled)) else $error("slave ref not scaled");
  a_can_ref: assert property (r.src == SRC_CAN |=>
    speed_ref == $past(can_ref) && reverse_cmd == $past(can_reverse))
    else $error("can ref wrong");
  a_enable_gate: assert property (r.src >= SRC_FIELDBUS &&
    r.src <= SRC_CAN && !en |=> !run_cmd) else $error("ran without DI1");
  a_pwr_lock: assert property (r.fsm == RUN_IDLE && pu_done &&
    r.first && !r.autostart |=> !run_cmd)
    else $error("autostart off but started");
  a_latch_stop: assert property (r.src == SRC_TERMINAL &&
    cls == CLS_LATCH && !db[0] |=> !run_cmd) else $error("stop open ran");
  a_latch_dir: assert property (r.src == SRC_TERMINAL &&
    cls == CLS_LATCH |=> reverse_cmd == $past(db[1]))
    else $error("direction select ignored");
  a_pulse_start: assert property (r.src == SRC_TERMINAL &&
    cls == CLS_PULSE && rise[0] && db[1] && r.fsm == RUN_IDLE &&
    pu_done && !r.first |=> run_cmd) else $error("start edge missed");
  a_pulse_stop: assert property (r.src == SRC_TERMINAL &&
    cls != CLS_LATCH && cls != CLS_RUNDIR && fall[1] |=> !run_cmd)
    else $error("stop edge missed");
  a_pair_start: assert property (r.src == SRC_TERMINAL &&
    cls == CLS_PAIR && !(db[0] && db[2]) |=> !$rose(run_cmd))
    else $error("paired start with one input");

  c_term_run: cover property (r.src == SRC_TERMINAL ##1 $rose(run_cmd));
  c_lockout:  cover property (r.fsm == RUN_LOCK ##1 r.fsm == RUN_IDLE);
  c_slave:    cover property (r.src == SRC_SLAVE && run_cmd);
  c_kpd_flip: cover property (r.src == SRC_KPD_BI && $changed(reverse_cmd));

endmodule // dcs_top

/* verification/dcs_contacts.sv */
// contact model for the terminal inputs, bit 0 is the enable contact
// assumes want changes just after a clock edge
`timescale 1ns/1ps
module dcs_contacts (
  input  wire logic       aclk,
  input  wire logic [4:0] want,
  output logic      [4:0] di_pin
);
  // ----------------------------------------------------------
  // changed contacts chatter a few cycles before settling
  // ----------------------------------------------------------
  logic [4:0] held;
  logic [4:0] chg;
  logic [2:0] bnc;
  initial begin
    held   = 5'h00;
    chg    = 5'h00;
    bnc    = 3'h0;
    di_pin = 5'h00;
  end
  // each changed contact, the enable one included, chatters back to its old level both while closing and while opening
  always @(posedge aclk) begin
    if (want != held) begin
      chg  <= want ^ held;
      held <= want;
      bnc  <= 3'h5;
    end else if (bnc != 3'h0) begin
      bnc <= bnc - 3'h1;
    end
    di_pin <= held ^ (bnc[0] ? chg : 5'h00); // bounce
  end
endmodule // dcs_contacts

/* verification/tb_dcs_top.sv */
// bench for dcs_top: register bus and each command source
// assumes the contact model drives the terminal pins
`timescale 1ns/1ps
module tb_dcs_top
  import dcs_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, run_cmd;
  logic        reverse_cmd, option_fitted, fb_run, fb_reverse, mb_run;
  logic        mb_reverse, ms_run, ms_reverse, can_run, can_reverse;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [4:0]  di_pin, want;
  logic [7:0]  awaddr, araddr;
  logic [15:0] ai1_ref, pid_ref, fb_ref, mb_ref, ms_ref, can_ref;
  logic [15:0] speed_ref;
  logic [31:0] wdata, rdata;
  int          fails, compares;

  dcs_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .di_pin, .ai1_ref,
    .pid_ref, .option_fitted, .fb_run, .fb_reverse, .fb_ref, .mb_run,
    .mb_reverse, .mb_ref, .ms_run, .ms_reverse, .ms_ref, .can_run,
    .can_reverse, .can_ref, .run_cmd, .reverse_cmd, .speed_ref);
  dcs_contacts i_contacts (.aclk(aclk), .want(want), .di_pin(di_pin));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  always #5 aclk = ~aclk;
  task automatic chk(input string n, input logic [33:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic drv(input logic r, v, input logic [15:0] s);
    repeat (4) @(posedge aclk);
    chk("drive", {16'h0, r, v, s}, {16'h0, run_cmd, reverse_cmd, speed_ref});
  endtask
  // write: address and data offered together, bready held until answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (!bvalid) @(posedge aclk);
    chk("bresp", {32'h0, er}, {32'h0, bresp});
    bready  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    chk("read", e, {rresp, rdata});
    rready  <= 1'b0;
  endtask
  // contacts need a full debounce window before the core sees them
  task automatic pins(input logic [4:0] w);
    @(posedge aclk);
    want <= w;
    repeat (120) @(posedge aclk);
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    rd(REG_CTRL, {RESP_OKAY, 32'h0000_0100});
    rd(REG_SCALE, {RESP_OKAY, 32'h0000_0100});
    rd(8'h14, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h14, 32'h0000_0000, RESP_SLVERR);
  endtask
  task automatic t_term;
    drv(1'b0, 1'b0, 16'h0ABC);
    pins(5'h01);
    drv(1'b1, 1'b0, 16'h0ABC);
    pins(5'h03);
    drv(1'b1, 1'b1, 16'h0ABC);
    pins(5'h01);
    pins(5'h00);
    drv(1'b0, 1'b0, 16'h0ABC);
    wr(REG_CTRL, 32'h0000_0800);
    pins(5'h02);
    drv(1'b1, 1'b1, 16'h0ABC);
    pins(5'h01);
    drv(1'b1, 1'b0, 16'h0ABC);
    pins(5'h00);
    drv(1'b0, 1'b0, 16'h0ABC);
  endtask
  task automatic t_bus;
    wr(REG_CTRL, 32'h0000_0004);
    mb_run <= 1'b1;
    drv(1'b0, 1'b0, 16'h1111);
    mb_run <= 1'b0;
    pins(5'h01);
    mb_run <= 1'b1;
    drv(1'b1, 1'b0, 16'h1111);
    mb_run        <= 1'b0;
    option_fitted <= 1'b1;
    fb_run        <= 1'b1;
    fb_reverse    <= 1'b1;
    drv(1'b1, 1'b1, 16'h2222);
    pins(5'h00);
    drv(1'b0, 1'b1, 16'h2222);
    fb_run <= 1'b0;
  endtask
  task automatic t_others;
    wr(REG_SCALE, 32'h0000_0200);
    wr(REG_CTRL, 32'h0000_0005);
    pins(5'h01);
    ms_run     <= 1'b1;
    ms_reverse <= 1'b1;
    drv(1'b1, 1'b1, 16'h2468);
    ms_run <= 1'b0;
    wr(REG_CTRL, 32'h0000_0006);
    can_run <= 1'b1;
    drv(1'b1, 1'b0, 16'h0777);
    can_run <= 1'b0;
    wr(REG_CTRL, 32'h0000_0003);
    drv(1'b1, 1'b0, 16'h0333);
    wr(REG_CTRL, 32'h0004_0001);
    wr(REG_KEYPAD, 32'h0500_0002);
    drv(1'b0, 1'b0, 16'h0500);
    wr(REG_KEYPAD, 32'h0500_0001);
    drv(1'b1, 1'b0, 16'h0500);
  endtask
  task automatic t_pulse;
    pins(5'h00);
    wr(REG_CTRL, 32'h0000_0C00);
    pins(5'h02);
    pins(5'h03);
    pins(5'h02);
    drv(1'b1, 1'b0, 16'h0ABC);
    pins(5'h00);
    drv(1'b0, 1'b0, 16'h0ABC);
  endtask

  // paired start, directional edges, then keypad with DI1 start
  task automatic t_edges;
    wr(REG_CTRL, 32'h0000_1000);
    pins(5'h02);
    pins(5'h03);
    drv(1'b0, 1'b0, 16'h0ABC);
    pins(5'h07);
    drv(1'b1, 1'b0, 16'h0ABC);
    pins(5'h05);
    drv(1'b0, 1'b0, 16'h0ABC);
    wr(REG_CTRL, 32'h0000_1200);
    pins(5'h02);
    pins(5'h06);
    drv(1'b1, 1'b1, 16'h0ABC);
    pins(5'h04);
    drv(1'b0, 1'b1, 16'h0ABC);
    pins(5'h02);
    pins(5'h03);
    drv(1'b1, 1'b0, 16'h0ABC);
    pins(5'h00);
    wr(REG_CTRL, 32'h0002_0002);
    pins(5'h01);
    drv(1'b1, 1'b0, 16'h0000);
    wr(REG_KEYPAD, 32'h0500_0001);
    drv(1'b1, 1'b1, 16'h0500);
    pins(5'h00);
    drv(1'b0, 1'b1, 16'h0500);
  endtask
  // reset in mid-run with DI1 held: locked out, or autostart if set
  task automatic t_power(input logic au);
    wr(REG_CTRL, 32'h0000_0100);
    pins(5'h01);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    if (au) begin
      wr(REG_CTRL, 32'h0001_0100);
    end
    repeat (150) @(posedge aclk);
    drv(au, 1'b0, 16'h0ABC);
  endtask

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole run needs about 4400 cycles
  initial begin
    #300us;
    fails++;
    report_and_stop();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {fb_run, fb_reverse, mb_run, mb_reverse, ms_run} = 5'h00;
    {ms_reverse, can_run, option_fitted} = 3'h0;
    {fails, compares} = {32'sd0, 32'sd0};
    can_reverse = 1'b0;
    {wstrb, want, awaddr, araddr, wdata} = {4'hF, 5'h00, 8'h00, 8'h00, 32'h0};
    {ai1_ref, pid_ref, fb_ref} = {16'h0ABC, 16'h0333, 16'h2222};
    {mb_ref, ms_ref, can_ref} = {16'h1111, 16'h1234, 16'h0777};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (150) @(posedge aclk);
    t_regs();
    t_term();
    t_bus();
    t_others();
    t_pulse();
    t_edges();
    t_power(1'b0);
    rd(REG_STATUS, {RESP_OKAY, 32'h0000_0104});
    rd(REG_SPEED, {RESP_OKAY, 32'h0000_0ABC});
    pins(5'h00);
    pins(5'h01);
    drv(1'b1, 1'b0, 16'h0ABC);
    t_power(1'b1);
    report_and_stop();
  end
endmodule // tb_dcs_top
